// File: logic/mcrb_main_clock.v
`include "mcrb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module mcrb_main_clock (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Core power state
	input wire halt_exec,
	input wire ext_wake,
	input wire global_irq_mask,
	output wire active_halt,
	output wire full_halt,
	output wire irq,
	output wire wake,
	// Clock outputs
	output wire core_clock_en,
	output wire clock_out_pin,
	output wire clock_out_oe,
	output wire beep_pin,
	output wire beep_oe
);
	localparam PW_RUN = 2'b00;
	localparam PW_AHALT = 2'b01;
	localparam PW_HALT = 2'b10;

	reg [7:0] ccs_q;
	reg [1:0] beep_q;
	reg [1:0] pw_q;
	reg [17:0] tb_cnt_q;
	reg [1:0] tb_act_q;
	reg [3:0] pre_q;
	reg ce_q;
	reg cko_q;
	reg [13:0] bp_cnt_q;
	reg bp_q;
	reg [31:0] rd_q;
	reg [17:0] tb_lim;
	reg [13:0] bp_lim;
	reg ce_d;
	reg rdy_q;

	// Access phase: first edge latches read data, second edge completes
	wire acc = psel & penable;
	wire wr = acc & rdy_q & pwrite;
	wire rd = acc & rdy_q & ~pwrite;
	wire rd_first = acc & ~rdy_q & ~pwrite;
	wire hit_ccs = (paddr == `MCRB_ADDR_CCS);
	wire hit_beep = (paddr == `MCRB_ADDR_BEEP);
	wire frozen = (pw_q != PW_RUN);
	wire tb_run = (pw_q != PW_HALT);
	wire tb_end = tb_run && (tb_cnt_q == tb_lim - 18'd1);

	assign pready = acc & rdy_q;
	assign pslverr = psel & penable & ~(hit_ccs | hit_beep);
	assign prdata = rd_q;

	// Period select from the latched time base
	always @* begin
		case (tb_act_q)
		2'b00: tb_lim = `MCRB_TB0_CYC;
		2'b01: tb_lim = `MCRB_TB1_CYC;
		2'b10: tb_lim = `MCRB_TB2_CYC;
		default: tb_lim = `MCRB_TB3_CYC;
		endcase
	end

	// Beep half period from the beep field
	always @* begin
		case (beep_q)
		2'b01: bp_lim = `MCRB_BEEP0_HALF;
		2'b10: bp_lim = `MCRB_BEEP1_HALF;
		default: bp_lim = `MCRB_BEEP2_HALF;
		endcase
	end

	// Registers, flag and power state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccs_q <= `MCRB_CCS_RST;
			beep_q <= 2'b00;
			pw_q <= PW_RUN;
			rd_q <= 32'h0000_0000;
			rdy_q <= 1'b0;
		end else begin
			// One wait state so read data stands when pready is sampled
			rdy_q <= acc & ~rdy_q;
			if (rd_first && !frozen)
				rd_q <= hit_ccs ? {24'h00_0000, ccs_q} :
					hit_beep ? {30'h0000_0000, beep_q} : 32'h0000_0000;
			if (wr && hit_ccs && !frozen)
				ccs_q[7:1] <= pwdata[7:1];
			if (wr && hit_beep && !frozen)
				beep_q <= pwdata[1:0];
			// Flag set wins over read clear
			if (tb_end)
				ccs_q[`MCRB_CCS_FLAG] <= 1'b1;
			else if (rd && hit_ccs && !frozen)
				ccs_q[`MCRB_CCS_FLAG] <= 1'b0;
			case (pw_q)
			PW_RUN: begin
				if (halt_exec)
					pw_q <= ccs_q[`MCRB_CCS_IE] ? PW_AHALT : PW_HALT;
			end
			PW_AHALT: begin
				if (tb_end || irq || ext_wake)
					pw_q <= PW_RUN;
			end
			PW_HALT: begin
				if (ext_wake)
					pw_q <= PW_RUN;
			end
			default: pw_q <= PW_RUN;
			endcase
		end
	end

	// Time-base counter, period change taken only at period end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_cnt_q <= 18'd0;
			tb_act_q <= 2'b00;
		end else if (tb_run) begin
			if (tb_end) begin
				tb_cnt_q <= 18'd0;
				tb_act_q <= ccs_q[`MCRB_CCS_TB_HI:`MCRB_CCS_TB_LO];
			end else begin
				tb_cnt_q <= tb_cnt_q + 18'd1;
			end
		end
	end

	// Core clock prescaler enable
	always @* begin
		case (ccs_q[`MCRB_CCS_DIV_HI:`MCRB_CCS_DIV_LO])
		2'b00: ce_d = (pre_q[0] == 1'b1);
		2'b01: ce_d = (pre_q[1:0] == 2'b11);
		2'b10: ce_d = (pre_q[2:0] == 3'b111);
		default: ce_d = (pre_q == 4'hF);
		endcase
		if (!ccs_q[`MCRB_CCS_SLOW])
			ce_d = 1'b1;
	end

	// Prescaler counter, clock-out and beep dividers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 4'h0;
			ce_q <= 1'b1;
			cko_q <= 1'b0;
			bp_cnt_q <= 14'd0;
			bp_q <= 1'b0;
		end else begin
			pre_q <= pre_q + 4'h1;
			ce_q <= ce_d;
			cko_q <= ccs_q[`MCRB_CCS_OUTSEL] && pw_q != PW_AHALT ? ~cko_q : 1'b0;
			if (beep_q == 2'b00 || pw_q == PW_HALT) begin
				bp_cnt_q <= 14'd0;
				bp_q <= 1'b0;
			end else if (bp_cnt_q == bp_lim - 14'd1) begin
				bp_cnt_q <= 14'd0;
				bp_q <= ~bp_q;
			end else begin
				bp_cnt_q <= bp_cnt_q + 14'd1;
			end
		end
	end

	assign irq = ccs_q[`MCRB_CCS_FLAG] & ccs_q[`MCRB_CCS_IE] & ~global_irq_mask;
	assign wake = irq;
	assign active_halt = (pw_q == PW_AHALT);
	assign full_halt = (pw_q == PW_HALT);
	assign core_clock_en = ce_q;
	assign clock_out_pin = cko_q;
	assign clock_out_oe = ccs_q[`MCRB_CCS_OUTSEL];
	assign beep_pin = bp_q;
	assign beep_oe = (beep_q != 2'b00);
endmodule // mcrb_main_clock
`default_nettype wire

// File: logic/mcrb_defs.vh
`ifndef MCRB_DEFS_VH
`define MCRB_DEFS_VH
// Register byte addresses (printed offsets 2Ch, 2Dh are register indexes; byte address is index times 4)
`define MCRB_IDX_CCS 8'h2C
`define MCRB_IDX_BEEP 8'h2D
`define MCRB_ADDR_CCS 12'h0B0
`define MCRB_ADDR_BEEP 12'h0B4
// Control/status field positions
`define MCRB_CCS_OUTSEL 7
`define MCRB_CCS_DIV_HI 6
`define MCRB_CCS_DIV_LO 5
`define MCRB_CCS_SLOW 4
`define MCRB_CCS_TB_HI 3
`define MCRB_CCS_TB_LO 2
`define MCRB_CCS_IE 1
`define MCRB_CCS_FLAG 0
// Reset values
`define MCRB_CCS_RST 8'h00
`define MCRB_BEEP_RST 8'h00
// Time-base periods in oscillator cycles
`define MCRB_TB0_CYC 18'd16000
`define MCRB_TB1_CYC 18'd32000
`define MCRB_TB2_CYC 18'd80000
`define MCRB_TB3_CYC 18'd200000
// Beep half periods at 8 MHz oscillator (2 kHz, 1 kHz, 500 Hz)
`define MCRB_BEEP0_HALF 14'd2000
`define MCRB_BEEP1_HALF 14'd4000
`define MCRB_BEEP2_HALF 14'd8000
`endif

// File: tb/mcrb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcrb_core_model (
	// Core requests
	input wire logic pclk, halt_req, mask_req,
	output logic halt_exec = 1'b0, global_irq_mask = 1'b0
);
	// One-cycle halt pulse, mask level
	always @(posedge pclk) begin
		halt_exec <= halt_req && !halt_exec;
		global_irq_mask <= mask_req;
	end
endmodule // mcrb_core_model
`default_nettype wire

// File: tb/mcrb_main_clock_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.vh"
module mcrb_props (
	// Bus and power state
	input wire logic pclk, presetn, psel, penable, pslverr, halt_exec, ext_wake,
	input wire logic [11:0] paddr,
	input wire logic global_irq_mask, active_halt, full_halt, irq,
	input wire logic clock_out_pin, clock_out_oe, beep_pin, beep_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mask; irq |-> !global_irq_mask; endproperty
	a_mask: assert property (p_mask) else $error("irq masked");
	property p_one; !(active_halt && full_halt); endproperty
	a_one: assert property (p_one) else $error("two halts");
	property p_halt; halt_exec && !active_halt && !full_halt |=> active_halt || full_halt; endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_fh; full_halt && !ext_wake |=> full_halt; endproperty
	a_fh: assert property (p_fh) else $error("halt left");
	property p_ah; active_halt [*3] |-> $stable(clock_out_pin); endproperty
	a_ah: assert property (p_ah) else $error("clock in halt");
	property p_co; (clock_out_oe && !active_halt && !full_halt) [*3]
		|-> clock_out_pin != $past(clock_out_pin); endproperty
	a_co: assert property (p_co) else $error("no clock out");
	property p_bo; !beep_oe [*2] |-> !beep_pin; endproperty
	a_bo: assert property (p_bo) else $error("beep off");
	property p_err; psel && penable && paddr != `MCRB_ADDR_CCS
		&& paddr != `MCRB_ADDR_BEEP |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no slverr");
endmodule // mcrb_props
bind mcrb_main_clock mcrb_props u_props (.*);
`default_nettype wire

// File: tb/main_clock_rtc_beeper_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.vh"
module main_clock_rtc_beeper_tb_top;
	// Bench signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic ext_wake = 0, halt_req = 0, mask_req = 0, se;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, r;
	wire [31:0] prdata;
	wire pready, pslverr, halt_exec, global_irq_mask, active_halt, full_halt, irq, wake;
	wire core_clock_en, clock_out_pin, clock_out_oe, beep_pin, beep_oe;
	int error_cnt = 0, compares = 0, cyc = 0, t0;
	localparam logic [11:0] C = `MCRB_ADDR_CCS, B = `MCRB_ADDR_BEEP;
	always #4 pclk = ~pclk;
	mcrb_main_clock dut (.*);
	mcrb_core_model core (.*);
	task wrap_up;
		if (error_cnt == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	// Bus cycle; answer taken as it stands before the completing edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		@(negedge pclk);
		while (!pready) begin
			@(posedge pclk);
			@(negedge pclk);
		end
		se = pslverr;
		r = prdata;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Halt and wake pulses
	task hl;
		halt_req <= 1;
		@(posedge pclk) halt_req <= 0;
		repeat (2) @(posedge pclk);
	endtask
	task wk;
		ext_wake <= 1;
		@(posedge pclk) ext_wake <= 0;
		repeat (2) @(posedge pclk);
	endtask
	// Cycle count and hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 99000) begin
			error_cnt++;
			wrap_up;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, C, 0);
		chk("ccs", r, 0);
		apb(0, B, 0);
		chk("beep", r, 0);
		apb(0, 12'h0c0, 0);
		chk("slverr", se, 1);
		for (int k = 1; k < 4; k++) begin
			apb(1, B, k);
			@(beep_pin) t0 = cyc;
			@(beep_pin) chk("half", cyc - t0, 1000 << k);
		end
		apb(1, C, 32'h0000_0092);
		chk("oe", clock_out_oe, 1);
		chk("irq", irq, 1);
		@(negedge pclk) t0 = core_clock_en;
		@(negedge pclk) chk("ce", core_clock_en, !t0);
		apb(0, C, 0);
		chk("flag", r, 32'h0000_0093);
		apb(0, C, 0);
		chk("clr", r, 32'h0000_0092);
		apb(1, C, 32'h0000_0086);
		@(posedge irq) t0 = cyc;
		apb(0, C, 0);
		chk("flag2", r, 32'h0000_0087);
		@(posedge irq) chk("period", cyc - t0, 32000);
		apb(0, C, 0);
		hl;
		chk("ahalt", active_halt, 1);
		apb(1, B, 0);
		chk("frozen", beep_oe, 1);
		wk;
		chk("run", active_halt, 0);
		apb(1, C, 0);
		hl;
		chk("fhalt", full_halt, 1);
		wk;
		chk("wake", full_halt, 0);
		wrap_up;
	end
endmodule // main_clock_rtc_beeper_tb_top
`default_nettype wire
